// ### hw/vsc_pkg.sv
// Shared constants and types for the serial display command link
package vsc_pkg;
  // Timing, all times in ns
  localparam int CLK_NS = 5;
  localparam int RST_PW_NS = 2000;
  localparam int READY_NS = 3000000;
  localparam int HALF_NS = 1000;
  localparam int CS_GAP_NS = 1000;
  localparam int DOFF_NS = 2000;
  localparam int RST_PW_CYC = (RST_PW_NS + CLK_NS - 1) / CLK_NS;
  localparam int READY_CYC = (READY_NS + CLK_NS - 1) / CLK_NS;
  localparam int HALF_CYC = (HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int CS_GAP_CYC = (CS_GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int DOFF_CYC = (DOFF_NS + CLK_NS - 1) / CLK_NS;
  localparam int HCNT_W = 20;

  // Display geometry
  localparam int ANODES = 35;
  localparam int GRIDS = 16;
  localparam logic [4:0] SLOTS = 5'd24;
  localparam logic [7:0] SLOT_TICKS = 8'hff;
  localparam logic [7:0] DUTY_MAX = 8'hf0;

  // Command decode
  localparam logic [7:0] OP_DIM_MASK = 8'hfc;
  localparam logic [7:0] OP_DIM = 8'he4;
  localparam logic [7:0] OP_LIGHT_MASK = 8'hfc;
  localparam logic [7:0] OP_LIGHT = 8'he8;
  localparam logic [7:0] OP_GRAY_MASK = 8'he0;
  localparam logic [7:0] OP_GRAY = 8'ha0;
  localparam logic [7:0] OP_LVL_MASK = 8'he0;
  localparam logic [7:0] OP_LVL = 8'hc0;
  localparam logic [2:0] SEL_BANK_A = 3'h0;
  localparam logic [2:0] SEL_BANK_B = 3'h1;
  localparam int LIGHT_HS_BIT = 0;
  localparam int LIGHT_LS_BIT = 1;

  // Reset values
  localparam logic [7:0] DUTY_RST = 8'h00;
  localparam logic [7:0] LEVEL_RST = 8'h00;
  localparam logic [4:0] LVL_ADDR_RST = 5'h00;
  localparam logic HIGH_RST = 1'b0;
  localparam logic LOW_RST = 1'b1;

  // Controller register map (AXI4-Lite, byte addresses)
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_RESET = 8'h08;
  localparam int CMD_TWO_BIT = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {
    VSC_RX_CMD = 2'b01,
    VSC_RX_DATA = 2'b10
  } vsc_rx_t;

  typedef enum logic [8:0] {
    VSC_H_RST = 9'b000000001,
    VSC_H_WAIT = 9'b000000010,
    VSC_H_IDLE = 9'b000000100,
    VSC_H_SETUP = 9'b000001000,
    VSC_H_LOW = 9'b000010000,
    VSC_H_HIGH = 9'b000100000,
    VSC_H_GAP = 9'b001000000,
    VSC_H_HOLD = 9'b010000000,
    VSC_H_CSW = 9'b100000000
  } vsc_host_st_t;
endpackage

// ### hw/vsc_link_if.sv
// Three-wire serial link plus reset pin between controller and display
interface vsc_link_if;
  logic cs_n;
  logic serial_shift_clock;
  logic serial_data_in;
  logic reset_n;
  modport device (
    input cs_n,
    input serial_shift_clock,
    input serial_data_in,
    input reset_n
  );
  modport host (
    output cs_n,
    output serial_shift_clock,
    output serial_data_in,
    output reset_n
  );
endinterface

// ### hw/vsc_device.sv
// Display end: serial command receiver, dimming, gray level and grid scan
// What this block does
// RULE_01: Dimming second byte stores grid duty value.
// RULE_02: Grid on-time duty/255, saturating at 240.
// RULE_03: Reset clears grid duty to zero.
// RULE_04: Host sets dimming before enabling display.
// RULE_05: Gray command: selector 0 bank A, 1 B.
// RULE_06: Anode gray duty value/255, saturating at 240.
// RULE_07: Reset clears gray levels; host writes nonzero.
// RULE_08: Per-slot enable bits for banks A, B.
// RULE_09: Light command forces all outputs on/off.
// RULE_10: All-high drives anodes high, duties kept.
// RULE_11: All-low drives every anode low.
// RULE_12: Sample data on shift clock rise, LSB first.
// RULE_13: Ignore link while chip select high.
// RULE_14: Reset pin low restores every initial state.
// RULE_15: Host waits 3 ms after reset release.
// RULE_16: Grid n lit only in slot n.
// RULE_17: Character addresses 0-15 map slots 0-15.
// RULE_18: Level RAM address increments per data byte.
// RULE_19: Reset leaves all-low set, all-high clear.
// RULE_20: Reset clears level RAM and address.
// RULE_21: All-low wins over all-high.
// RULE_22: Chip select high restarts byte framing.
module vsc_device
  import vsc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  vsc_link_if.device link,
  input wire logic [ANODES-1:0] pattern_a,
  input wire logic [ANODES-1:0] pattern_b,
  output logic [4:0] scan_slot,
  output logic [GRIDS-1:0] grid,
  output logic [ANODES-1:0] anode_bank_a,
  output logic [ANODES-1:0] anode_bank_b,
  output logic [7:0] grid_duty_value,
  output logic [7:0] level_a,
  output logic [7:0] level_b,
  output logic [GRIDS-1:0] level_enable_a,
  output logic [GRIDS-1:0] level_enable_b,
  output logic all_outputs_high,
  output logic all_outputs_low
);
  typedef struct packed {
    logic [1:0] cs_s;
    logic [1:0] sck_s;
    logic [1:0] sdi_s;
    logic [1:0] rst_s;
    logic sck_prev;
    vsc_rx_t rx;
    logic [2:0] bitcnt;
    logic [7:0] shreg;
    logic [7:0] cmd;
    logic [7:0] duty;
    logic [7:0] lvl_a;
    logic [7:0] lvl_b;
    logic [GRIDS-1:0] en_a;
    logic [GRIDS-1:0] en_b;
    logic [4:0] lvl_addr;
    logic all_hi;
    logic all_lo;
    logic [7:0] tick;
    logic [4:0] slot;
    logic [GRIDS-1:0] grid;
    logic [ANODES-1:0] an_a;
    logic [ANODES-1:0] an_b;
  } vsc_dev_t;

  localparam vsc_dev_t DEV_RST = '{
    cs_s: 2'h3,
    rst_s: 2'h3,
    rx: VSC_RX_CMD,
    duty: DUTY_RST,
    lvl_a: LEVEL_RST,
    lvl_b: LEVEL_RST,
    lvl_addr: LVL_ADDR_RST,
    all_hi: HIGH_RST,
    all_lo: LOW_RST,
    default: '0
  };

  vsc_dev_t q;
  vsc_dev_t d;
  logic sck_rise;
  logic [7:0] rx_byte;
  logic grid_on;
  logic on_a;
  logic on_b;
  logic slot_en_a;
  logic slot_en_b;

  function automatic logic [7:0] vsc_sat(input logic [7:0] v);
    return (v > DUTY_MAX) ? DUTY_MAX : v;
  endfunction

  assign sck_rise = q.sck_s[1] & ~q.sck_prev;
  assign rx_byte = {q.sdi_s[1], q.shreg[7:1]};
  assign grid_on = q.tick < vsc_sat(q.duty); // [RULE_02]
  assign slot_en_a = (q.slot < 5'(GRIDS)) ? q.en_a[q.slot[3:0]] : 1'b0;
  assign slot_en_b = (q.slot < 5'(GRIDS)) ? q.en_b[q.slot[3:0]] : 1'b0;
  // Enabled slots take the bank's gray duty, others follow the grid
  assign on_a = slot_en_a ? (q.tick < vsc_sat(q.lvl_a)) : grid_on; // [RULE_06]
  assign on_b = slot_en_b ? (q.tick < vsc_sat(q.lvl_b)) : grid_on; // [RULE_08]

  always_comb begin
    d = q;
    if (!q.rst_s[1]) begin
      d = DEV_RST; // [RULE_14] [RULE_03] [RULE_07] [RULE_19] [RULE_20]
    end
    d.cs_s = {q.cs_s[0], link.cs_n};
    d.sck_s = {q.sck_s[0], link.serial_shift_clock};
    d.sdi_s = {q.sdi_s[0], link.serial_data_in};
    d.rst_s = {q.rst_s[0], link.reset_n};
    d.sck_prev = q.sck_s[1];

    if (q.rst_s[1]) begin
      if (q.cs_s[1]) begin
        // Partial bytes are dropped so a glitchy frame cannot skew the next
        d.bitcnt = 3'h0; // [RULE_13] [RULE_22]
        d.rx = VSC_RX_CMD;
      end else if (sck_rise) begin
        d.shreg = rx_byte; // [RULE_12]
        d.bitcnt = q.bitcnt + 3'h1;
        if (q.bitcnt == 3'h7) begin
          if (q.rx == VSC_RX_CMD) begin
            d.cmd = rx_byte;
            d.rx = VSC_RX_DATA;
            if ((rx_byte & OP_LIGHT_MASK) == OP_LIGHT) begin
              d.all_hi = rx_byte[LIGHT_HS_BIT]; // [RULE_09]
              d.all_lo = rx_byte[LIGHT_LS_BIT];
            end
            if ((rx_byte & OP_LVL_MASK) == OP_LVL) begin
              d.lvl_addr = rx_byte[4:0];
            end
          end else begin
            if ((q.cmd & OP_DIM_MASK) == OP_DIM) begin
              d.duty = rx_byte; // [RULE_01]
            end
            if ((q.cmd & OP_GRAY_MASK) == OP_GRAY) begin
              // Selector codes other than the two banks are ignored
              if (q.cmd[2:0] == SEL_BANK_A) begin
                d.lvl_a = rx_byte; // [RULE_05]
              end else if (q.cmd[2:0] == SEL_BANK_B) begin
                d.lvl_b = rx_byte;
              end
            end
            if ((q.cmd & OP_LVL_MASK) == OP_LVL) begin
              if (q.lvl_addr < 5'(GRIDS)) begin
                d.en_a[q.lvl_addr[3:0]] = rx_byte[0]; // [RULE_08]
                d.en_b[q.lvl_addr[3:0]] = rx_byte[1];
              end
              d.lvl_addr = q.lvl_addr + 5'h1; // [RULE_18]
            end
          end
        end
      end

      if (q.tick == SLOT_TICKS - 8'h1) begin
        d.tick = 8'h0;
        d.slot = (q.slot == SLOTS - 5'h1) ? 5'h0 : q.slot + 5'h1;
      end else begin
        d.tick = q.tick + 8'h1;
      end

      for (int g = 0; g < GRIDS; g++) begin
        d.grid[g] = (q.slot == 5'(g)) && grid_on; // [RULE_16]
      end

      if (q.all_lo) begin
        d.an_a = '0; // [RULE_11] [RULE_21]
        d.an_b = '0;
      end else if (q.all_hi) begin
        d.an_a = {ANODES{on_a}}; // [RULE_10]
        d.an_b = {ANODES{on_b}};
      end else begin
        d.an_a = pattern_a & {ANODES{on_a}};
        d.an_b = pattern_b & {ANODES{on_b}};
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= DEV_RST;
    end else if (clk_en) begin
      q <= d;
    end
  end

  // Slot index selects the character address whose pixels arrive next
  assign scan_slot = q.slot; // [RULE_17]
  assign grid = q.grid;
  assign anode_bank_a = q.an_a;
  assign anode_bank_b = q.an_b;
  assign grid_duty_value = q.duty;
  assign level_a = q.lvl_a;
  assign level_b = q.lvl_b;
  assign level_enable_a = q.en_a;
  assign level_enable_b = q.en_b;
  assign all_outputs_high = q.all_hi;
  assign all_outputs_low = q.all_lo;
endmodule // vsc_device

// ### hw/vsc_host.sv
// Controller end: AXI4-Lite command registers driving the serial link
module vsc_host
  import vsc_pkg::*;
#(
  parameter int READY_WAIT_CYC = READY_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  vsc_link_if.host link,
  input wire logic [7:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic [7:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready
);
  typedef struct packed {
    vsc_host_st_t st;
    logic [HCNT_W-1:0] cnt;
    logic [2:0] bitn;
    logic second;
    logic [7:0] sh;
    logic [16:0] cmd;
    logic cs_n;
    logic sck;
    logic sdi;
    logic rst_n;
    logic aw_have;
    logic w_have;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } vsc_host_t;

  localparam vsc_host_t HOST_RST = '{
    st: VSC_H_RST,
    cs_n: 1'b1,
    sck: 1'b1,
    default: '0
  };

  vsc_host_t q;
  vsc_host_t d;
  logic idle;

  assign idle = (q.st == VSC_H_IDLE);

  always_comb begin
    d = q;
    d.cnt = q.cnt + HCNT_W'(1);
    case (q.st)
      VSC_H_RST: begin
        d.rst_n = 1'b0;
        if (q.cnt == HCNT_W'(RST_PW_CYC - 1)) begin
          d.rst_n = 1'b1;
          d.cnt = '0;
          d.st = VSC_H_WAIT;
        end
      end
      VSC_H_WAIT: begin
        if (q.cnt == HCNT_W'(READY_WAIT_CYC - 1)) begin
          d.st = VSC_H_IDLE; // [RULE_15]
        end
      end
      VSC_H_IDLE: d.cnt = '0;
      VSC_H_SETUP: begin
        if (q.cnt == HCNT_W'(CS_GAP_CYC - 1)) begin
          d.sck = 1'b0;
          d.sdi = q.sh[0]; // [RULE_12]
          d.cnt = '0;
          d.st = VSC_H_LOW;
        end
      end
      VSC_H_LOW: begin
        if (q.cnt == HCNT_W'(HALF_CYC - 1)) begin
          d.sck = 1'b1;
          d.cnt = '0;
          d.st = VSC_H_HIGH;
        end
      end
      VSC_H_HIGH: begin
        if (q.cnt == HCNT_W'(HALF_CYC - 1)) begin
          d.cnt = '0;
          if (q.bitn != 3'h7) begin
            d.bitn = q.bitn + 3'h1;
            d.sh = {1'b0, q.sh[7:1]};
            d.sdi = q.sh[1];
            d.sck = 1'b0;
            d.st = VSC_H_LOW;
          end else if (q.cmd[CMD_TWO_BIT] && !q.second) begin
            d.bitn = 3'h0;
            d.second = 1'b1;
            d.sh = q.cmd[15:8];
            d.st = VSC_H_GAP;
          end else begin
            d.st = VSC_H_HOLD;
          end
        end
      end
      VSC_H_GAP: begin
        // Device needs time to process a byte before the next one
        if (q.cnt == HCNT_W'(DOFF_CYC - 1)) begin
          d.sck = 1'b0;
          d.sdi = q.sh[0];
          d.cnt = '0;
          d.st = VSC_H_LOW;
        end
      end
      VSC_H_HOLD: begin
        if (q.cnt == HCNT_W'(CS_GAP_CYC - 1)) begin
          d.cs_n = 1'b1;
          d.cnt = '0;
          d.st = VSC_H_CSW;
        end
      end
      VSC_H_CSW: begin
        if (q.cnt == HCNT_W'(CS_GAP_CYC - 1)) begin
          d.st = VSC_H_IDLE;
        end
      end
      default: d = HOST_RST;
    endcase

    if (s_axil_awvalid && q.awready) begin
      d.aw_have = 1'b1;
      d.awaddr = s_axil_awaddr;
    end
    if (s_axil_wvalid && q.wready) begin
      d.w_have = 1'b1;
      d.wdata = s_axil_wdata;
    end
    if (q.bvalid && s_axil_bready) begin
      d.bvalid = 1'b0;
    end
    if (q.aw_have && q.w_have && !q.bvalid) begin
      d.aw_have = 1'b0;
      d.w_have = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = RESP_OKAY;
      if (q.awaddr == REG_CMD) begin
        // Zero gray level is refused; it would leave the bank dark
        if (!idle || ((q.wdata[7:0] & OP_GRAY_MASK) == OP_GRAY &&
            q.wdata[CMD_TWO_BIT] && q.wdata[15:8] == 8'h00)) begin
          d.bresp = RESP_SLVERR; // [RULE_07] [RULE_06]
        end else begin
          d.cmd = q.wdata[16:0];
          d.sh = q.wdata[7:0];
          d.bitn = 3'h0;
          d.second = 1'b0;
          d.cs_n = 1'b0; // [RULE_13]
          d.cnt = '0;
          d.st = VSC_H_SETUP;
        end
      end else if (q.awaddr == REG_RESET) begin
        if (idle && q.wdata[0]) begin
          d.cnt = '0;
          d.st = VSC_H_RST;
        end else if (!idle) begin
          d.bresp = RESP_SLVERR;
        end
      end else begin
        d.bresp = RESP_DECERR;
      end
    end

    if (q.rvalid && s_axil_rready) begin
      d.rvalid = 1'b0;
    end
    if (s_axil_arvalid && q.arready) begin
      d.rvalid = 1'b1;
      d.rresp = RESP_OKAY;
      d.rdata = '0;
      case (s_axil_araddr)
        REG_CMD: d.rdata = {15'h0, q.cmd};
        REG_STATUS: d.rdata = {30'h0, q.rst_n, idle};
        REG_RESET: d.rdata = '0;
        default: d.rresp = RESP_DECERR;
      endcase
    end
    d.awready = !d.aw_have && !d.bvalid;
    d.wready = !d.w_have && !d.bvalid;
    d.arready = !d.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= HOST_RST;
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign link.cs_n = q.cs_n;
  assign link.serial_shift_clock = q.sck;
  assign link.serial_data_in = q.sdi;
  assign link.reset_n = q.rst_n;
  assign s_axil_awready = q.awready;
  assign s_axil_wready = q.wready;
  assign s_axil_bvalid = q.bvalid;
  assign s_axil_bresp = q.bresp;
  assign s_axil_arready = q.arready;
  assign s_axil_rvalid = q.rvalid;
  assign s_axil_rdata = q.rdata;
  assign s_axil_rresp = q.rresp;
endmodule // vsc_host

// ### tb/vsc_link_properties.sv
// Concurrent checks on the serial link and the display outputs
module vsc_properties
  import vsc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic cs_n,
  input wire logic serial_shift_clock,
  input wire logic serial_data_in,
  input wire logic reset_n,
  input wire logic [4:0] scan_slot,
  input wire logic [GRIDS-1:0] grid,
  input wire logic [ANODES-1:0] anode_bank_a,
  input wire logic [ANODES-1:0] anode_bank_b,
  input wire logic [7:0] grid_duty_value,
  input wire logic [GRIDS-1:0] level_enable_a,
  input wire logic [GRIDS-1:0] level_enable_b,
  input wire logic all_outputs_high,
  input wire logic all_outputs_low
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic on;
  logic sck_q;
  logic on_q;
  logic [4:0] rise_q;
  logic [8:0] run_q;
  logic [7:0] duty_s_q;

  assign on = |grid;

  // Run length of each grid pulse, with the duty seen when it started
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sck_q <= 1'b1;
      on_q <= 1'b0;
      rise_q <= 5'h00;
      run_q <= 9'h000;
      duty_s_q <= 8'h00;
    end else begin
      sck_q <= serial_shift_clock;
      on_q <= on;
      if (cs_n) begin
        rise_q <= 5'h00;
      end else if (serial_shift_clock && !sck_q) begin
        rise_q <= rise_q + 5'h01;
      end
      if (on) begin
        run_q <= on_q ? run_q + 9'h001 : 9'h001;
      end
      if (on && !on_q) begin
        duty_s_q <= grid_duty_value;
      end
    end
  end

  chk_sck_idle_high: assert property (cs_n |-> serial_shift_clock)
    else $error("shift clock low outside a frame");
  chk_cs_setup: assert property ($fell(cs_n) |-> serial_shift_clock [*8])
    else $error("shift clock fell too soon after select");
  chk_data_stable: assert property (
    !cs_n && $changed(serial_data_in) |-> $fell(serial_shift_clock))
    else $error("data moved away from the falling clock");
  chk_frame_bits: assert property (
    $rose(cs_n) |-> rise_q == 5'h08 || rise_q == 5'h10)
    else $error("frame did not carry whole bytes");
  chk_grid_slot: assert property (grid != 16'h0000 |->
    $past(scan_slot) < 5'd16 && grid == (16'h0001 << $past(scan_slot)))
    else $error("grid does not match scan slot");
  chk_grid_ontime: assert property ($fell(on) && duty_s_q == grid_duty_value
    |-> run_q == {1'b0, (grid_duty_value > DUTY_MAX) ? DUTY_MAX
                                                     : grid_duty_value})
    else $error("grid on-time differs from duty");
  chk_low_blanks: assert property ($past(all_outputs_low) |->
    anode_bank_a == '0 && anode_bank_b == '0)
    else $error("anodes lit while blanked");
  chk_high_lights: assert property ($past(all_outputs_high)
    && !$past(all_outputs_low) && level_enable_a == 16'h0000
    && level_enable_b == 16'h0000 && on
    |-> &anode_bank_a && &anode_bank_b)
    else $error("anodes not all high in test mode");
  chk_pin_reset: assert property (!reset_n [*6] |-> all_outputs_low
    && !all_outputs_high && grid_duty_value == DUTY_RST
    && level_enable_a == 16'h0000 && grid == 16'h0000)
    else $error("reset pin did not restore initial state");

  cov_test_lit: cover property (all_outputs_high && !all_outputs_low && on);
  cov_grid_run: cover property ($fell(on) && run_q == 9'h0f0);
  cov_two_bytes: cover property ($rose(cs_n) && rise_q == 5'h10);
  cov_pin_reset: cover property ($fell(reset_n));
endmodule // vsc_properties

// ### tb/vfd_serial_command_control_tb.sv
// Self-checking bench: host and display ends joined over the serial link
module vfd_serial_command_control_tb
  import vsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [34:0] pat_a = '0;
  logic [34:0] pat_b = '0;
  logic [7:0] awaddr = '0;
  logic [7:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [4:0] scan_slot;
  logic [15:0] grid, level_enable_a, level_enable_b;
  logic [34:0] anode_bank_a, anode_bank_b;
  logic [7:0] grid_duty_value, level_a, level_b;
  logic all_outputs_high, all_outputs_low;
  int err_count = 0;
  int n_checks = 0;
  int seed = 84;
  logic [1:0] exp_b[$];
  logic [57:0] exp_s[$];
  logic [57:0] st, st_q, e;
  localparam logic [57:0] ST_RST = {8'h00, 8'h00, 8'h00, 32'h0, 2'b01};

  initial forever #2.5 aclk = ~aclk;

  vsc_link_if vsc_link_if_i ();
  vsc_host #(.READY_WAIT_CYC(50)) vsc_host_i (.aclk(aclk),
    .aresetn(aresetn), .clk_en(1'b1), .link(vsc_link_if_i),
    .s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid),
    .s_axil_awready(awready), .s_axil_wdata(wdata), .s_axil_wstrb(4'hf),
    .s_axil_wvalid(wvalid), .s_axil_wready(wready), .s_axil_bresp(bresp),
    .s_axil_bvalid(bvalid), .s_axil_bready(bready), .s_axil_araddr(araddr),
    .s_axil_arvalid(arvalid), .s_axil_arready(arready),
    .s_axil_rdata(rdata), .s_axil_rresp(rresp), .s_axil_rvalid(rvalid),
    .s_axil_rready(rready));
  vsc_device vsc_device_i (.aclk(aclk), .aresetn(aresetn), .clk_en(1'b1),
    .link(vsc_link_if_i), .pattern_a(pat_a), .pattern_b(pat_b),
    .scan_slot(scan_slot), .grid(grid), .anode_bank_a(anode_bank_a),
    .anode_bank_b(anode_bank_b), .grid_duty_value(grid_duty_value),
    .level_a(level_a), .level_b(level_b), .level_enable_a(level_enable_a),
    .level_enable_b(level_enable_b), .all_outputs_high(all_outputs_high),
    .all_outputs_low(all_outputs_low));
  vsc_properties vsc_properties_i (.aclk(aclk), .aresetn(aresetn),
    .cs_n(vsc_link_if_i.cs_n),
    .serial_shift_clock(vsc_link_if_i.serial_shift_clock),
    .serial_data_in(vsc_link_if_i.serial_data_in),
    .reset_n(vsc_link_if_i.reset_n), .scan_slot(scan_slot), .grid(grid),
    .anode_bank_a(anode_bank_a), .anode_bank_b(anode_bank_b),
    .grid_duty_value(grid_duty_value), .level_enable_a(level_enable_a),
    .level_enable_b(level_enable_b), .all_outputs_high(all_outputs_high),
    .all_outputs_low(all_outputs_low));

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic tmo(input int n);
    if (n >= 4000) begin
      err_count++;
      $display("Error %0t: wait ran out", $time);
      test_done();
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] r);
    int n;
    bit aw;
    bit w;
    exp_b.push_back(r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw = 1;
    w = 1;
    n = 0;
    while ((aw || w) && n < 4000) begin
      @(posedge aclk);
      n++;
      if (aw && awready) begin
        aw = 0;
        awvalid <= 1'b0;
      end
      if (w && wready) begin
        w = 0;
        wvalid <= 1'b0;
      end
    end
    tmo(n);
    n = 0;
    while (!bvalid && n < 4000) begin
      @(posedge aclk);
      n++;
    end
    tmo(n);
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (!arready && n < 4000);
    tmo(n);
    arvalid <= 1'b0;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (!rvalid && n < 4000);
    tmo(n);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic idle();
    logic [31:0] d;
    logic [1:0] r;
    int n;
    n = 0;
    do begin
      axr(REG_STATUS, d, r);
      n++;
    end while (d[0] !== 1'b1 && n < 4000);
    tmo(n);
  endtask

  task automatic cmd(input logic [7:0] b0, input logic [7:0] b1,
                     input logic two, input logic [1:0] r);
    idle();
    axw(REG_CMD, {15'h0000, two, b1, b0}, r);
  endtask

  always @(posedge aclk) begin
    pat_a <= 35'({$random(seed), $random(seed)});
    pat_b <= 35'({$random(seed), $random(seed)});
  end

  // Stored command state, compared whenever it moves
  assign st = {grid_duty_value, level_a, level_b, level_enable_a,
               level_enable_b, all_outputs_high, all_outputs_low};
  always @(posedge aclk) begin
    st_q <= st;
    if (aresetn && st !== st_q) begin
      if (exp_s.size() > 0) chk(64'(st), 64'(exp_s.pop_front()));
      else chk(64'(st), 64'(st_q));
    end
    if (bvalid && bready) chk(64'(bresp), 64'(exp_b.pop_front()));
  end

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] v;
    e = ST_RST;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    idle();
    chk(64'(st), 64'(ST_RST));
    axr(8'h0c, d, r);
    chk({d, 30'h0, r}, {32'h0, 30'h0, RESP_DECERR});
    axw(8'h0c, 32'h0, RESP_DECERR);
    $display("reset test done");
    // Back-to-back write checks that a busy host refuses a second order
    v = 8'h01 | (8'($random(seed)) & 8'h7f);
    for (int i = 0; i < 2; i++) begin
      e[57:50] = v;
      exp_s.push_back(e);
      cmd(OP_DIM, v, 1'b1, RESP_OKAY);
      axw(REG_CMD, {16'h0001, OP_DIM}, RESP_SLVERR);
      v = 8'hf5;
    end
    $display("dimming test done");
    for (int s = 0; s < 3; s++) begin
      v = 8'($random(seed)) | 8'h01;
      if (s == 0) e[49:42] = v;
      if (s == 1) e[41:34] = v;
      if (s < 2) exp_s.push_back(e);
      cmd(OP_GRAY | 8'(s), v, 1'b1, RESP_OKAY);
    end
    cmd(OP_GRAY, 8'h00, 1'b1, RESP_SLVERR);
    $display("gray level test done");
    for (int k = 0; k < 3; k++) begin
      v = (k == 0) ? 8'he9 : ((k == 1) ? 8'heb : 8'he8);
      e[1:0] = {v[0], v[1]};
      exp_s.push_back(e);
      cmd(v, 8'h00, 1'b0, RESP_OKAY);
    end
    $display("light test done");
    e[21] = 1'b1;
    e[5] = 1'b1;
    exp_s.push_back(e);
    cmd(8'hc3, 8'h03, 1'b1, RESP_OKAY);
    e[33] = 1'b1;
    exp_s.push_back(e);
    cmd(8'hcf, 8'h01, 1'b1, RESP_OKAY);
    $display("level enable test done");
    idle();
    exp_s.push_back(ST_RST);
    axw(REG_RESET, 32'h1, RESP_OKAY);
    axw(REG_RESET, 32'h1, RESP_SLVERR);
    axw(REG_CMD, {16'h0001, OP_DIM}, RESP_SLVERR);
    idle();
    repeat (20) @(posedge aclk);
    chk(64'(exp_s.size()), 64'h0);
    $display("reset pin test done");
    test_done();
  end
endmodule // vfd_serial_command_control_tb
